// File: verilog/pfp_pkg.sv
// Shared constants and carrier types for phase fault summary and power-good control
// Notes on behaviour
// [R1] Broadcast selector reads back the per-phase fault map
// [R2] Single-phase selector reads that phase's fault details
// [R3] Unassigned or disabled phase bits read zero
// [R4] Bits 15:4 zero; bits 3:0 flag faulted phases
// [R5] Summary word at DCh, word access, live
// [R6] Config word at E3h, loaded from nonvolatile source
// [R7] Config writable only while conversion is disabled
// [R8] Assert delay code at 15:12, 1 or 2^N+1
// [R9] Release delay code at 11:8, same encoding
// [R10] Bits 7:2 mask output events from pulling low
// [R11] Bits 1:0 mask input overvoltage events
// [R12] Forced low when disabled or sequencing or faulted
// [R13] Fall and fault shutdown bypass the assert delay
// [R14] Continue-operating response keeps fault from pulling low
// [R15] Assert and release delays use separate timers
// [R16] Short events below delay difference never pull low
// [R17] Timers restart when their condition goes away
package pfp_pkg;

  // Command codes of the two words
  localparam logic [7:0] CMD_PHASE_FAULT_SUMMARY = 8'hDC;
  localparam logic [7:0] CMD_POWER_GOOD_CONFIG = 8'hE3;

  // Phase selector values that mean all phases
  localparam logic [7:0] PHASE_ALL = 8'hFF;
  localparam logic [7:0] PHASE_BCAST = 8'h80;

  // Number of phases in a stack
  localparam int NUM_PHASES = 4;

  // Power-good config field layout
  localparam int CFG_ASSERT_DLY_LSB = 12;
  localparam int CFG_RELEASE_DLY_LSB = 8;
  localparam int DLY_CODE_W = 4;

  // Reset values before the nonvolatile load
  localparam logic [15:0] SUMMARY_RESET = 16'h0000;
  localparam logic [15:0] CONFIG_RESET = 16'h0000;

  // Delay timer width: 2^15+1 cycles must fit
  localparam int DLY_CNT_W = 17;

  // System clock cycles per PWM clock enable pulse
  localparam int PWM_DIV_CYCLES = 250;

  // Monitored events in config bit order (bit 7 down to bit 0)
  typedef struct packed {
    logic out_ov_fault;
    logic out_ov_warn;
    logic out_uv_fault;
    logic out_uv_warn;
    logic out_oc_warn;
    logic out_oc_fault;
    logic in_ov_warn;
    logic in_ov_fault;
  } pfp_evt_t;

  // One Read Word or Write Word transaction
  typedef struct packed {
    logic write;
    logic [7:0] code;
    logic [15:0] wdata;
  } pfp_cmd_t;

  // Answer to a transaction
  typedef struct packed {
    logic error;
    logic [15:0] rdata;
  } pfp_rsp_t;

endpackage

// File: verilog/pfp_delay_timer.sv
// Delay timer counting PWM clock pulses while its condition holds
`timescale 1ns/1ns
module pfp_delay_timer #(
  parameter int CNT_W = pfp_pkg::DLY_CNT_W
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // PWM clock enable and timed condition
  input wire logic pwm_tick,
  input wire logic cond,
  input wire logic [pfp_pkg::DLY_CODE_W-1:0] code,
  // High once the condition has lasted the full delay
  output logic expired
);

  logic [CNT_W-1:0] cnt_reg;
  logic [CNT_W-1:0] cnt_inc;
  logic [CNT_W-1:0] target;
  logic reach;

  // Code 0 gives one PWM clock, code N gives 2^N+1
  assign target = (code == 4'h0) ? {{(CNT_W-1){1'b0}}, 1'b1} :
                  (({{(CNT_W-1){1'b0}}, 1'b1} << code) + {{(CNT_W-1){1'b0}}, 1'b1}); // [R8] [R9]
  assign cnt_inc = cnt_reg + {{(CNT_W-1){1'b0}}, 1'b1};
  assign reach = (cnt_inc == target);

  // Counting restarts from zero as soon as the condition drops
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      cnt_reg <= '0;
      expired <= 1'b0;
    end else if (!cond) begin
      cnt_reg <= '0; // [R17]
      expired <= 1'b0;
    end else if (pwm_tick && !expired) begin
      cnt_reg <= cnt_inc;
      expired <= reach;
    end
  end

endmodule // pfp_delay_timer

// File: verilog/pfp_phase_fault_power_good_output.sv
// Phase fault summary word and power-good output control
`timescale 1ns/1ns
module pfp_phase_fault_power_good_output #(
  parameter int PWM_DIV = pfp_pkg::PWM_DIV_CYCLES
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // Decoded word transactions from the management bus
  input wire logic cmd_valid,
  input wire pfp_pkg::pfp_cmd_t cmd,
  output logic rsp_valid,
  output pfp_pkg::pfp_rsp_t rsp,
  // Phase selector and phase numbering
  input wire logic [7:0] phase_sel,
  input wire logic [pfp_pkg::NUM_PHASES-1:0] phase_assigned,
  input wire logic [pfp_pkg::NUM_PHASES-1:0] phase_fault_set,
  input wire logic [15:0] phase_detail,
  // Power-up value of the power-good config
  input wire logic [15:0] nvm_config,
  // Fault and warning levels, and their continue-operating responses
  input wire pfp_pkg::pfp_evt_t evt,
  input wire pfp_pkg::pfp_evt_t evt_continue,
  // Conversion and sequencing state
  input wire logic conv_enabled,
  input wire logic in_ton_delay,
  input wire logic in_ton_rise,
  input wire logic in_toff_fall,
  input wire logic in_fault_shutdown,
  // Power-good level and live config
  output logic power_good_output,
  output logic [15:0] power_good_config
);

  localparam int DIV_W = (PWM_DIV > 1) ? $clog2(PWM_DIV) : 1;
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(PWM_DIV - 1);

  // Registers
  logic [pfp_pkg::NUM_PHASES-1:0] phase_flag_reg;
  logic [pfp_pkg::NUM_PHASES-1:0] phase_flag_next;
  logic [15:0] config_reg;
  logic [15:0] config_next;
  logic load_pending_reg;
  logic [DIV_W-1:0] div_reg;
  logic pwm_tick_reg;
  logic fault_latch_reg;
  logic fault_latch_next;
  logic pg_next;
  logic rsp_valid_next;
  pfp_pkg::pfp_rsp_t rsp_next;

  // Decoded transaction
  logic hit_summary;
  logic hit_config;
  logic wr_summary;
  logic wr_config;
  logic wr_config_refused;
  logic sel_broadcast;
  logic sel_single;
  logic [1:0] sel_index;
  logic [15:0] summary_map;
  logic [15:0] summary_read;
  logic [pfp_pkg::NUM_PHASES-1:0] clear_mask;
  logic [pfp_pkg::NUM_PHASES-1:0] sel_onehot;

  // Power-good decisions
  logic [3:0] assert_code;
  logic [3:0] release_code;
  pfp_pkg::pfp_evt_t evt_mask;
  logic [7:0] evt_live;
  logic unmasked_any;
  logic assert_expired;
  logic release_expired;
  logic force_low;
  logic bypass;

  // Transaction decoding
  assign hit_summary = (cmd.code == pfp_pkg::CMD_PHASE_FAULT_SUMMARY); // [R5]
  assign hit_config = (cmd.code == pfp_pkg::CMD_POWER_GOOD_CONFIG); // [R6]
  assign wr_summary = cmd_valid && cmd.write && hit_summary;
  // A config write during conversion is refused and leaves the word alone
  assign wr_config_refused = cmd_valid && cmd.write && hit_config && conv_enabled; // [R7]
  assign wr_config = cmd_valid && cmd.write && hit_config && !conv_enabled; // [R7]

  // Selector meaning: 80h counts as broadcast even though it is not FFh
  assign sel_broadcast = (phase_sel == pfp_pkg::PHASE_ALL) || (phase_sel == pfp_pkg::PHASE_BCAST); // [R1]
  assign sel_single = !sel_broadcast && (phase_sel < 8'h04);
  assign sel_index = phase_sel[1:0];

  // Fault map: only assigned phases can show a one, upper bits stay zero
  assign summary_map = {12'h000, phase_flag_reg & phase_assigned}; // [R3] [R4]
  // Single-phase reads hand back the selected phase's own fault word
  assign summary_read = sel_broadcast ? summary_map : phase_detail; // [R1] [R2]

  // Per-phase clear from a summary write
  genvar gi;
  generate
    for (gi = 0; gi < pfp_pkg::NUM_PHASES; gi++) begin : g_phase
      assign sel_onehot[gi] = sel_single && (sel_index == 2'(gi));
      // Broadcast write clears the ones written; single nonzero write clears the selected phase
      assign clear_mask[gi] = wr_summary && (sel_broadcast ? cmd.wdata[gi] : (sel_onehot[gi] && (cmd.wdata != 16'h0000)));
      // A new fault in the clearing cycle wins over the clear
      assign phase_flag_next[gi] = phase_fault_set[gi] || (phase_flag_reg[gi] && !clear_mask[gi]); // [R4]
    end
  endgenerate

  // Config word: nonvolatile value first, then host writes while disabled
  assign config_next = load_pending_reg ? nvm_config :
                       wr_config ? cmd.wdata : config_reg; // [R6] [R7]

  // Answer: data for reads, error for unknown codes and refused writes
  always_comb begin
    rsp_valid_next = cmd_valid;
    rsp_next.error = 1'b0;
    rsp_next.rdata = 16'h0000;
    if (!cmd_valid) begin
      rsp_next.error = 1'b0;
    end else if (hit_summary) begin
      rsp_next.rdata = cmd.write ? 16'h0000 : summary_read; // [R5]
    end else if (hit_config) begin
      rsp_next.rdata = cmd.write ? 16'h0000 : config_reg;
      rsp_next.error = wr_config_refused; // [R7]
    end else begin
      rsp_next.error = 1'b1;
    end
  end

  // Register file and bus answer
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      phase_flag_reg <= pfp_pkg::SUMMARY_RESET[pfp_pkg::NUM_PHASES-1:0];
      config_reg <= pfp_pkg::CONFIG_RESET;
      load_pending_reg <= 1'b1;
      rsp_valid <= 1'b0;
      rsp <= '0;
    end else begin
      phase_flag_reg <= phase_flag_next;
      config_reg <= config_next;
      load_pending_reg <= 1'b0;
      rsp_valid <= rsp_valid_next;
      rsp <= rsp_next;
    end
  end

  // PWM clock enable: one pulse every PWM_DIV system cycles
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      div_reg <= '0;
      pwm_tick_reg <= 1'b0;
    end else begin
      div_reg <= (div_reg == DIV_LAST) ? '0 : div_reg + DIV_W'(1);
      pwm_tick_reg <= (div_reg == DIV_LAST);
    end
  end

  // Config fields
  assign assert_code = config_reg[pfp_pkg::CFG_ASSERT_DLY_LSB +: pfp_pkg::DLY_CODE_W]; // [R8]
  assign release_code = config_reg[pfp_pkg::CFG_RELEASE_DLY_LSB +: pfp_pkg::DLY_CODE_W]; // [R9]
  assign evt_mask = config_reg[7:0]; // [R10] [R11]

  // An event counts only when unmasked and not set to ride through
  assign evt_live = evt & ~evt_mask & ~evt_continue; // [R10] [R11] [R14]
  assign unmasked_any = |evt_live;

  // Sequencing states that hold power-good low outright
  assign force_low = !conv_enabled || in_ton_delay || in_ton_rise || in_toff_fall || in_fault_shutdown; // [R12]
  assign bypass = in_toff_fall || in_fault_shutdown; // [R13]

  // Assert timer runs on events, release timer on their absence
  pfp_delay_timer #(
    .CNT_W(pfp_pkg::DLY_CNT_W)
  ) u_assert_timer (
    .mclk(mclk),
    .rstn(rstn),
    .pwm_tick(pwm_tick_reg),
    .cond(unmasked_any),
    .code(assert_code),
    .expired(assert_expired)
  ); // [R15]

  pfp_delay_timer #(
    .CNT_W(pfp_pkg::DLY_CNT_W)
  ) u_release_timer (
    .mclk(mclk),
    .rstn(rstn),
    .pwm_tick(pwm_tick_reg),
    .cond(!unmasked_any),
    .code(release_code),
    .expired(release_expired)
  ); // [R15]

  // Fault latch: outside fall and fault shutdown, an event shorter than the assert delay never sets it,
  // so brief glitches leave power-good high whatever the release delay is
  assign fault_latch_next = (unmasked_any && (assert_expired || bypass)) ? 1'b1 :
                            release_expired ? 1'b0 : fault_latch_reg; // [R8] [R9] [R13] [R16]

  // Power-good high only when nothing forces or latches it low
  assign pg_next = !force_low && !fault_latch_next; // [R12] [R14]

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      fault_latch_reg <= 1'b0;
      power_good_output <= 1'b0;
      power_good_config <= pfp_pkg::CONFIG_RESET;
    end else begin
      fault_latch_reg <= fault_latch_next;
      power_good_output <= pg_next;
      power_good_config <= config_next;
    end
  end

endmodule // pfp_phase_fault_power_good_output

// File: test/pfp_phase_fault_power_good_output_properties.sv
// Checker for phase fault summary and power-good control
`timescale 1ns/1ns
module pfp_phase_fault_power_good_output_properties #(
  parameter int PWM_DIV = pfp_pkg::PWM_DIV_CYCLES
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // Word transactions
  input wire logic cmd_valid,
  input wire pfp_pkg::pfp_cmd_t cmd,
  input wire logic rsp_valid,
  input wire pfp_pkg::pfp_rsp_t rsp,
  // Phase inputs
  input wire logic [7:0] phase_sel,
  input wire logic [pfp_pkg::NUM_PHASES-1:0] phase_assigned,
  input wire logic [pfp_pkg::NUM_PHASES-1:0] phase_fault_set,
  input wire logic [15:0] phase_detail,
  input wire logic [15:0] nvm_config,
  // Events and sequencing
  input wire pfp_pkg::pfp_evt_t evt,
  input wire pfp_pkg::pfp_evt_t evt_continue,
  input wire logic conv_enabled,
  input wire logic in_ton_delay,
  input wire logic in_ton_rise,
  input wire logic in_toff_fall,
  input wire logic in_fault_shutdown,
  // Outputs
  input wire logic power_good_output,
  input wire logic [15:0] power_good_config
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);
  // Decoded causes; config only moves while forced low, so it is safe to use live
  wire live_evt = |(evt & ~power_good_config[7:0] & ~evt_continue);
  wire force_low = !conv_enabled || in_ton_delay || in_ton_rise || in_toff_fall || in_fault_shutdown;
  wire rd_sum = cmd_valid && !cmd.write && cmd.code == pfp_pkg::CMD_PHASE_FAULT_SUMMARY;
  wire bcast = phase_sel == pfp_pkg::PHASE_ALL || phase_sel == pfp_pkg::PHASE_BCAST;
  wire wr_cfg = cmd_valid && cmd.write && cmd.code == pfp_pkg::CMD_POWER_GOOD_CONFIG;
  wire bad_code = cmd.code != pfp_pkg::CMD_PHASE_FAULT_SUMMARY && cmd.code != pfp_pkg::CMD_POWER_GOOD_CONFIG;
  AST_RSP_NEXT: assert property (cmd_valid |=> rsp_valid) else $error("no answer");
  AST_RSP_CAUSE: assert property (rsp_valid |-> $past(cmd_valid)) else $error("stray answer");
  AST_SUM_MAP: assert property (rd_sum && bcast |=> rsp.rdata[15:4] == 12'h000
    && (rsp.rdata[3:0] & ~$past(phase_assigned)) == 4'h0) else $error("bad phase map");
  AST_SUM_DETAIL: assert property (rd_sum && !bcast |=> rsp.rdata == $past(phase_detail))
    else $error("bad detail");
  AST_CFG_LOCK: assert property (wr_cfg && conv_enabled |=> rsp.error && $stable(power_good_config))
    else $error("config changed while converting");
  AST_CFG_WRITE: assert property (wr_cfg && !conv_enabled |=>
    !rsp.error && power_good_config == $past(cmd.wdata)) else $error("config write lost");
  AST_BAD_CODE: assert property (cmd_valid && bad_code |=> rsp.error && rsp.rdata == 16'h0000)
    else $error("bad code");
  AST_FORCE_LOW: assert property (force_low |=> !power_good_output) else $error("not forced low");
  AST_FALL_CAUSE: assert property ($fell(power_good_output) |-> $past(force_low) || $past(live_evt, 2))
    else $error("low without cause");
  // A rise straight out of a forced-low state may meet a live event whose assert delay has not run out yet
  AST_RISE_CAUSE: assert property ($rose(power_good_output) |->
    !$past(force_low) && ($past(force_low, 2) || !$past(live_evt, 2))) else $error("released too early");
  // Main scenarios
  COV_REFUSED: cover property (rsp_valid && rsp.error);
  COV_PG_FALL: cover property ($fell(power_good_output) && conv_enabled);
  COV_PG_RISE: cover property ($rose(power_good_output));
endmodule // pfp_phase_fault_power_good_output_properties

bind pfp_phase_fault_power_good_output pfp_phase_fault_power_good_output_properties #(.PWM_DIV(PWM_DIV)) u_props (
  .mclk(mclk),
  .rstn(rstn),
  .cmd_valid(cmd_valid),
  .cmd(cmd),
  .rsp_valid(rsp_valid),
  .rsp(rsp),
  .phase_sel(phase_sel),
  .phase_assigned(phase_assigned),
  .phase_fault_set(phase_fault_set),
  .phase_detail(phase_detail),
  .nvm_config(nvm_config),
  .evt(evt),
  .evt_continue(evt_continue),
  .conv_enabled(conv_enabled),
  .in_ton_delay(in_ton_delay),
  .in_ton_rise(in_ton_rise),
  .in_toff_fall(in_toff_fall),
  .in_fault_shutdown(in_fault_shutdown),
  .power_good_output(power_good_output),
  .power_good_config(power_good_config)
);

// File: test/pfp_host_model.sv
// Management bus host model issuing word transactions
`timescale 1ns/1ns
module pfp_host_model (
  // Clock
  input wire logic mclk,
  // Word transactions
  output logic cmd_valid,
  output pfp_pkg::pfp_cmd_t cmd,
  input wire logic rsp_valid,
  input wire pfp_pkg::pfp_rsp_t rsp
);
  initial begin
    cmd_valid = 1'b0;
    cmd = '0;
  end
  // One-cycle request; idle bus shows the inverse word so stale data never looks valid
  task automatic xfer(input logic w, input logic [7:0] code, input logic [15:0] d, output pfp_pkg::pfp_rsp_t r);
    int n;
    @(negedge mclk);
    cmd_valid = 1'b1;
    cmd = {w, code, d};
    @(negedge mclk);
    cmd_valid = 1'b0;
    cmd = ~cmd;
    for (n = 0; n < 4 && rsp_valid !== 1'b1; n++) @(negedge mclk);
    r = rsp_valid ? rsp : 'x;
  endtask
endmodule // pfp_host_model

// File: test/pfp_phase_fault_power_good_output_tb_top.sv
// Self-checking bench for phase fault summary and power-good control
`timescale 1ns/1ns
module pfp_phase_fault_power_good_output_tb_top;
  localparam int DIV = 2;
  logic mclk, rstn, cmd_valid, rsp_valid, conv_enabled, power_good_output;
  logic [3:0] seq, phase_assigned, phase_fault_set;
  logic [7:0] phase_sel;
  logic [15:0] phase_detail, nvm_config, power_good_config;
  pfp_pkg::pfp_cmd_t cmd;
  pfp_pkg::pfp_rsp_t rsp, r;
  pfp_pkg::pfp_evt_t evt, evt_continue;
  int num_errors = 0;
  int checks_done = 0;
  pfp_phase_fault_power_good_output #(.PWM_DIV(DIV)) dut (
    .mclk(mclk),
    .rstn(rstn),
    .cmd_valid(cmd_valid),
    .cmd(cmd),
    .rsp_valid(rsp_valid),
    .rsp(rsp),
    .phase_sel(phase_sel),
    .phase_assigned(phase_assigned),
    .phase_fault_set(phase_fault_set),
    .phase_detail(phase_detail),
    .nvm_config(nvm_config),
    .evt(evt),
    .evt_continue(evt_continue),
    .conv_enabled(conv_enabled),
    .in_ton_delay(seq[0]),
    .in_ton_rise(seq[1]),
    .in_toff_fall(seq[2]),
    .in_fault_shutdown(seq[3]),
    .power_good_output(power_good_output),
    .power_good_config(power_good_config)
  );
  pfp_host_model u_host (
    .mclk(mclk),
    .cmd_valid(cmd_valid),
    .cmd(cmd),
    .rsp_valid(rsp_valid),
    .rsp(rsp)
  );
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  task automatic compare_value(input logic [16:0] got, input logic [16:0] exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic xf(input logic w, input logic [7:0] c, input logic [15:0] d, input logic [16:0] exp);
    u_host.xfer(w, c, d, r);
    compare_value(r, exp);
  endtask
  // Bounded wait for a power-good level, elapsed cycles checked against a window
  task automatic wait_pg(input logic lvl, input int lo, input int hi);
    int c;
    for (c = 0; c < 2000 && power_good_output !== lvl; c++) @(negedge mclk);
    compare_value(17'(c >= lo && c <= hi), 17'h00001);
  endtask
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    #100000;
    num_errors++;
    tally_and_finish();
  end
  initial begin
    {rstn, conv_enabled, seq, phase_fault_set, evt, evt_continue} = '0;
    phase_sel = 8'hFF;
    phase_assigned = 4'hB;
    phase_detail = 16'hA5C3;
    nvm_config = 16'h2100;
    repeat (12) @(negedge mclk);
    rstn = 1'b1;
    repeat (2) @(negedge mclk);
    compare_value({1'b0, power_good_config}, 17'h02100);
    xf(1'b0, 8'hE3, 16'h0000, 17'h02100);
    xf(1'b1, 8'hE3, 16'h3000, 17'h00000);
    conv_enabled = 1'b1;
    xf(1'b1, 8'hE3, 16'h00FF, 17'h10000);
    xf(1'b0, 8'hE3, 16'h0000, 17'h03000);
    xf(1'b0, 8'hDD, 16'h0000, 17'h10000);
    $display("test registers done");
    phase_fault_set = 4'hF;
    @(negedge mclk);
    phase_fault_set = 4'h0;
    xf(1'b0, 8'hDC, 16'h0000, 17'h0000B);
    phase_sel = 8'h80;
    xf(1'b0, 8'hDC, 16'h0000, 17'h0000B);
    phase_sel = 8'h02;
    xf(1'b0, 8'hDC, 16'h0000, 17'h0A5C3);
    phase_sel = 8'hFF;
    xf(1'b1, 8'hDC, 16'h0001, 17'h00000);
    xf(1'b0, 8'hDC, 16'h0000, 17'h0000A);
    $display("test phase summary done");
    // Short pulses must not add up: together they outlast the assert delay, alone they do not
    wait_pg(1'b1, 0, 2000);
    repeat (4) begin
      evt = 8'h80;
      repeat (6) @(negedge mclk);
      evt = 8'h00;
      repeat (2) @(negedge mclk);
    end
    compare_value({16'h0000, power_good_output}, 17'h00001);
    evt = 8'h80;
    // Code 3 is nine ticks; the first tick lands somewhere in the first DIV cycles
    wait_pg(1'b0, 8 * DIV + 2, 9 * DIV + 1);
    evt = 8'h00;
    wait_pg(1'b1, 2, DIV + 1);
    for (int i = 0; i < 5; i++) begin
      if (i < 4) seq = 4'(1 << i);
      else conv_enabled = 1'b0;
      repeat (2) @(negedge mclk);
      compare_value({16'h0000, power_good_output}, 17'h00000);
      seq = 4'h0;
      conv_enabled = 1'b1;
      wait_pg(1'b1, 0, 20);
    end
    // Fall or shutdown latches a live event at once, so leaving it early still shows low
    for (int i = 2; i < 4; i++) begin
      seq = 4'(1 << i);
      evt = 8'h80;
      repeat (2) @(negedge mclk);
      seq = 4'h0;
      repeat (4) @(negedge mclk);
      compare_value({16'h0000, power_good_output}, 17'h00000);
      evt = 8'h00;
      wait_pg(1'b1, 2, DIV + 1);
    end
    $display("test power good timing done");
    for (int i = 0; i < 8; i++) begin
      conv_enabled = 1'b0;
      xf(1'b1, 8'hE3, {8'h00, ~(8'h01 << i)}, 17'h00000);
      conv_enabled = 1'b1;
      wait_pg(1'b1, 0, 20);
      evt = ~(8'h01 << i);
      repeat (10) @(negedge mclk);
      compare_value({16'h0000, power_good_output}, 17'h00001);
      evt_continue = 8'h01 << i;
      evt = 8'hFF;
      repeat (10) @(negedge mclk);
      compare_value({16'h0000, power_good_output}, 17'h00001);
      evt_continue = 8'h00;
      wait_pg(1'b0, 2, DIV + 1);
      evt = 8'h00;
    end
    $display("test masks done");
    tally_and_finish();
  end
endmodule // pfp_phase_fault_power_good_output_tb_top
